// ==== verilog/fco_pkg.sv ====
package fco_pkg;

  // ----------------------------------------------------------------
  // Cable and counter widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int PAR_W = 2;
  localparam int WORD_W = DATA_W + PAR_W;
  localparam int CTL_W = 3;
  localparam int CNT_W = 8;

  // ----------------------------------------------------------------
  // Timing, clock at 250 MHz
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int PULSE_NS = 12;
  localparam int SETUP_NS = 50;
  localparam int REQ_LOW_NS = 65;
  // Pulse length: a plain width, rounded up
  localparam int PULSE_CYC_I = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Set-up must be strictly more than the figure
  localparam int SETUP_CYC_I = SETUP_NS / CLK_PERIOD_NS + 1;
  // Least low time, rounded up
  localparam int REQ_LOW_CYC_I = (REQ_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] PULSE_CYC = CNT_W'(PULSE_CYC_I);
  localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'(SETUP_CYC_I);
  localparam logic [CNT_W-1:0] REQ_LOW_CYC = CNT_W'(REQ_LOW_CYC_I);

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // Control fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_DIR_BIT = 1;
  localparam int CTRL_POL_BIT = 2;
  localparam int CTRL_CLR_BIT = 3;
  localparam int CTRL_CTL_LSB = 4;

  // Status fields
  localparam int STAT_STS_LSB = 0;
  localparam int STAT_TEST_BIT = 3;
  localparam int STAT_ATTENTION_IN_BIT = 4;
  localparam int STAT_ACKLN_BIT = 5;
  localparam int STAT_ACKFF_BIT = 6;
  localparam int STAT_REQ_BIT = 7;
  localparam int STAT_BUSY_BIT = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Output handshake sequencer
  typedef enum logic [1:0] {
    FCO_IDLE = 2'b00,
    FCO_PULSE = 2'b01,
    FCO_SETUP = 2'b10,
    FCO_REQ = 2'b11
  } fco_state_t;

endpackage : fco_pkg

// ==== verilog/fco_sync.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Two-stage synchroniser for pin inputs
// ------------------------------------------------------------------
module fco_sync #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : fco_sync

// ==== verilog/fco_output_handshake.sv ====
`timescale 1ns/1ps
// Behaviour
// RL1: Control bit picks rising or falling acknowledge edge; falling is inverted phase.
// RL2: Idle state: enabled, output way, no clear, flag set, pulse and request idle.
// RL3: First ready word at FIFO output starts one active-low shift-out pulse at once.
// RL4: Each shift-out pulse clears acknowledge flag and pops one word to output register.
// RL5: After a delay past pulse end, request-holding flag sets and request asserts.
// RL6: Cable data is valid more than 50 ns before request asserts.
// RL7: Request stays low at least 65 ns before asserting again.
// RL8: Peripheral takes the word, then asserts acknowledge.
// RL9: Selected acknowledge edge sets the flag, dropping the request.
// RL10: Flag set and FIFO ready issue next pulse; cycle repeats.
// RL11: At transfer end flag stays set, request low, no further shift-out.
// RL12: Output register is both FIFO output stage and cable data source.
// RL13: Loopback test pin, active low, readable at status bit 3.
// RL14: Test pin forces data and parity drivers on; else off in input mode.
// RL15: In loopback, toggling polarity acts as acknowledge and pushes data into FIFO.
// RL16: Hood routes request to acknowledge, control to status, data out to in.
// RL17: Cable carries 16 data, 2 parity each way, 3 control, 3 status, more.
// RL18: Direction output follows control direction bit; high means card to peripheral.
// RL19: Polarity one uses falling acknowledge edge.
// RL20: Acknowledge synchronised; widths and delays are whole clock counts meeting minima.
// RL21: Edge is rising edge of acknowledge XOR polarity.
module fco_output_handshake (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [3:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [3:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  // FIFO side, same clock
  input wire logic fifo_out_ready,
  input wire logic [fco_pkg::WORD_W-1:0] fifo_out_data,
  output logic fifo_pop,
  output logic fifo_push,
  output logic [fco_pkg::WORD_W-1:0] fifo_push_data,
  output logic fifo_clear_n,
  // Cable side
  input wire logic peripheral_ack_in,
  output logic peripheral_request_out,
  output logic shift_out_pulse_n,
  output logic cable_way_out,
  output logic [fco_pkg::WORD_W-1:0] cable_data_out,
  output logic cable_data_oe,
  input wire logic [fco_pkg::WORD_W-1:0] cable_data_in,
  output logic [fco_pkg::CTL_W-1:0] control_out,
  input wire logic [fco_pkg::CTL_W-1:0] status_in,
  input wire logic attention_in,
  input wire logic test_pin_n
);
  import fco_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int SYN_W = WORD_W + CTL_W + 3;
  logic [SYN_W-1:0] syn_q;
  logic ack_s;
  logic test_s;
  logic attention_in_s;
  logic [CTL_W-1:0] sts_s;
  logic [WORD_W-1:0] din_s;

  // Test pin inverted ahead of the flops so their cleared state reads
  // as inactive; otherwise drivers would switch on right after reset
  fco_sync #(.W(SYN_W)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({peripheral_ack_in, ~test_pin_n, attention_in, status_in, cable_data_in}),
    .q(syn_q)
  );
  assign {ack_s, test_s, attention_in_s, sts_s, din_s} = syn_q; // RL20

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [31:0] stat_w;
  logic wr_go;
  logic peripheral_enable;
  logic dir_out;
  logic polarity;
  logic test_active;

  assign peripheral_enable = ctrl_r[CTRL_EN_BIT];
  assign dir_out = ctrl_r[CTRL_DIR_BIT];
  assign polarity = ctrl_r[CTRL_POL_BIT];
  assign test_active = test_s;

  // Address and data are taken together, one write at a time
  assign wr_go = s_axil_awvalid && s_axil_wvalid && !bvalid_r;
  assign s_axil_awready = wr_go;
  assign s_axil_wready = wr_go;
  assign s_axil_bvalid = bvalid_r;
  assign s_axil_bresp = bresp_r;
  assign s_axil_arready = !rvalid_r;
  assign s_axil_rvalid = rvalid_r;
  assign s_axil_rdata = rdata_r;
  assign s_axil_rresp = rresp_r;

  // Control register, byte lanes honoured; unused bits read as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_go && s_axil_awaddr == CTRL_OFS) begin
      for (int i = 0; i < 4; i++) begin
        if (s_axil_wstrb[i]) begin
          ctrl_r[i*8 +: 8] <= s_axil_wdata[i*8 +: 8];
        end
      end
      ctrl_r[31:CTRL_CTL_LSB+CTL_W] <= '0;
    end
  end

  // Write response; unmapped or status writes answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= (s_axil_awaddr == CTRL_OFS) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axil_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read path, answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (s_axil_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rresp_r <= RESP_OKAY;
      unique case (s_axil_araddr)
        CTRL_OFS: rdata_r <= ctrl_r;
        STAT_OFS: rdata_r <= stat_w;
        default: begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= RESP_SLVERR;
        end
      endcase
    end else if (s_axil_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Acknowledge edge detection
  // ----------------------------------------------------------------
  // Polarity folds in before the edge test, so changing it alone gives an edge
  // whenever ack XOR polarity turns high; that is what loopback relies on
  logic ack_comb;
  logic ack_comb_r;
  logic ack_edge;

  assign ack_comb = ack_s ^ polarity; // RL1 RL19 RL21
  assign ack_edge = ack_comb && !ack_comb_r; // RL21

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_comb_r <= 1'b0;
    end else begin
      ack_comb_r <= ack_comb;
    end
  end

  // ----------------------------------------------------------------
  // Output handshake sequencer
  // ----------------------------------------------------------------
  fco_state_t state_r;
  fco_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] low_cnt_r;
  logic ack_flag_r;
  logic req_r;
  logic [WORD_W-1:0] out_r;
  logic run_ok;
  logic start;

  // Transfer allowed only when enabled, outbound and not clearing
  assign run_ok = peripheral_enable && dir_out && !ctrl_r[CTRL_CLR_BIT]; // RL2
  assign start = (state_r == FCO_IDLE) && run_ok && ack_flag_r && fifo_out_ready; // RL3 RL10

  // Next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      FCO_IDLE: if (start) state_nxt = FCO_PULSE;
      FCO_PULSE: if (cnt_r == PULSE_CYC - 8'h01) state_nxt = FCO_SETUP;
      // Both set-up and least low time must have run out
      FCO_SETUP: begin
        if (cnt_r >= SETUP_CYC - 8'h01 && low_cnt_r >= REQ_LOW_CYC) begin
          state_nxt = FCO_REQ; // RL5 RL6 RL7
        end
      end
      FCO_REQ: if (ack_edge) state_nxt = FCO_IDLE; // RL9
    endcase
    if (!run_ok) begin
      state_nxt = FCO_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= FCO_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Phase counter, restarts on every state change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 8'h00;
    end else if (state_nxt != state_r) begin
      cnt_r <= 8'h00;
    end else if (cnt_r != 8'hFF) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  // Cycles since request fell; saturates, starts full after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt_r <= 8'hFF;
    end else if (req_r) begin
      low_cnt_r <= 8'h00;
    end else if (low_cnt_r != 8'hFF) begin
      low_cnt_r <= low_cnt_r + 8'h01;
    end
  end

  // Acknowledge flag: set on edge or while run_ok is low, cleared by a pulse;
  // a set in the clearing cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_flag_r <= 1'b1; // RL2
    end else if (ack_edge || !run_ok) begin
      ack_flag_r <= 1'b1; // RL9 RL11
    end else if (start) begin
      ack_flag_r <= 1'b0; // RL4
    end
  end

  // Request holding flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_r <= 1'b0;
    end else begin
      req_r <= (state_nxt == FCO_REQ); // RL5 RL9
    end
  end

  // Output register feeds the cable; the next FIFO read waits until the acknowledge flag is set again, by the acknowledge edge or by run_ok going low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_r <= '0;
    end else if (start) begin
      out_r <= fifo_out_data; // RL4 RL12
    end
  end

  assign fifo_pop = start; // RL4
  assign shift_out_pulse_n = (state_r != FCO_PULSE); // RL3
  assign peripheral_request_out = req_r;
  assign cable_data_out = out_r; // RL12
  assign cable_way_out = dir_out; // RL18
  assign cable_data_oe = test_active || dir_out; // RL14
  assign control_out = ctrl_r[CTRL_CTL_LSB +: CTL_W]; // RL17
  assign fifo_clear_n = ~ctrl_r[CTRL_CLR_BIT];

  // ----------------------------------------------------------------
  // Inbound capture for loopback
  // ----------------------------------------------------------------
  // Only this edge-to-FIFO path of the inbound side is kept here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fifo_push <= 1'b0;
      fifo_push_data <= '0;
    end else begin
      fifo_push <= ack_edge && !dir_out && peripheral_enable; // RL15
      fifo_push_data <= din_s;
    end
  end

  // Status word
  always_comb begin
    stat_w = 32'h0000_0000;
    stat_w[STAT_STS_LSB +: CTL_W] = sts_s;
    stat_w[STAT_TEST_BIT] = test_active; // RL13
    stat_w[STAT_ATTENTION_IN_BIT] = attention_in_s;
    stat_w[STAT_ACKLN_BIT] = ack_s;
    stat_w[STAT_ACKFF_BIT] = ack_flag_r;
    stat_w[STAT_REQ_BIT] = req_r;
    stat_w[STAT_BUSY_BIT] = (state_r != FCO_IDLE);
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] since_pop_r;

  // Cycles since the last pop, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since_pop_r <= 8'h00;
    end else if (fifo_pop) begin
      since_pop_r <= 8'h00;
    end else if (since_pop_r != 8'hFF) begin
      since_pop_r <= since_pop_r + 8'h01;
    end
  end

  sequence s_pulse_low;
    !shift_out_pulse_n [*3] ##1 shift_out_pulse_n;
  endsequence

  property p_start_pulse;
    @(posedge aclk) disable iff (!aresetn)
    start |=> $fell(shift_out_pulse_n) ##0 s_pulse_low;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("pulse not started"); // RL3

  property p_pop_with_pulse;
    @(posedge aclk) disable iff (!aresetn)
    fifo_pop |=> !ack_flag_r || $past(ack_edge) ##0 out_r == $past(fifo_out_data);
  endproperty
  a_pop_with_pulse: assert property (p_pop_with_pulse) else $error("pop bad"); // RL4

  property p_setup;
    @(posedge aclk) disable iff (!aresetn)
    $rose(peripheral_request_out) |-> since_pop_r > 8'd13 && $stable(cable_data_out);
  endproperty
  a_setup: assert property (p_setup) else $error("setup short"); // RL6

  property p_low_time;
    @(posedge aclk) disable iff (!aresetn)
    $rose(peripheral_request_out) |-> low_cnt_r >= 8'd17;
  endproperty
  a_low_time: assert property (p_low_time) else $error("request low too short"); // RL7

  property p_ack_drops_req;
    @(posedge aclk) disable iff (!aresetn)
    peripheral_request_out && ack_edge |=> !peripheral_request_out && ack_flag_r;
  endproperty
  a_ack_drops_req: assert property (p_ack_drops_req) else $error("request held"); // RL9

  property p_req_waits;
    @(posedge aclk) disable iff (!aresetn)
    peripheral_request_out && !ack_edge && run_ok |=> peripheral_request_out;
  endproperty
  a_req_waits: assert property (p_req_waits) else $error("request dropped"); // RL5

  property p_no_pop_unready;
    @(posedge aclk) disable iff (!aresetn)
    fifo_pop |-> fifo_out_ready && ack_flag_r;
  endproperty
  a_no_pop_unready: assert property (p_no_pop_unready) else $error("pop without ready"); // RL11

  property p_drive_en;
    @(posedge aclk) disable iff (!aresetn)
    test_active || dir_out |-> cable_data_oe;
  endproperty
  a_drive_en: assert property (p_drive_en) else $error("drivers off"); // RL14

  property p_loop_push;
    @(posedge aclk) disable iff (!aresetn)
    $changed(polarity) && !dir_out && peripheral_enable && $stable(ack_s) &&
      (ack_s ^ polarity) |=> fifo_push;
  endproperty
  a_loop_push: assert property (p_loop_push) else $error("loop push missing"); // RL15
endmodule : fco_output_handshake

// ==== verif/fco_periph_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Peripheral at the far end of the cable
// ------------------------------------------------------------------
module fco_periph_model (
  input wire logic aclk,
  input wire logic req,
  input wire logic [fco_pkg::WORD_W-1:0] data,
  input wire logic pol,
  input wire logic [7:0] delay,
  output logic ack,
  output logic [fco_pkg::WORD_W-1:0] word,
  output int count
);
  import fco_pkg::*;

  // One word per request; a long delay checks that data holds until ack
  initial begin
    ack = 1'b0;
    word = '0;
    count = 0;
    forever begin
      @(posedge aclk);
      if (req) begin
        repeat (delay) @(posedge aclk);
        word <= data;
        count <= count + 1;
        ack <= ~pol;
        // Release only once the card has dropped its request
        while (req) @(posedge aclk);
        ack <= pol;
      end else begin
        ack <= pol;
      end
    end
  end
endmodule : fco_periph_model

// ==== verif/tb_fco_output_handshake.sv ====
`timescale 1ns/1ps
module tb_fco_output_handshake;
  import fco_pkg::*;
  logic aclk, aresetn;
  logic [3:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, v;
  logic [1:0] bresp, rresp, r;
  logic fifo_pop, fifo_push, clr_n, req, pso_n, way, oe, test_n, m_ack, ack, m_pol;
  logic [WORD_W-1:0] mem [0:7];
  logic [WORD_W-1:0] dout, din, push_data, m_word, prev_dout;
  logic [2:0] rd, wr;
  logic [CTL_W-1:0] ctl;
  logic [7:0] m_delay;
  logic prev_req, fell;
  int m_count, mismatches, comparisons, plow, rlow, stable;

  // Hood loops request back; otherwise the peripheral answers
  assign ack = test_n ? m_ack : req;
  // Undriven data lines show the inverse of the last value
  assign din = (!test_n && oe) ? dout : ~dout;

  fco_output_handshake i_fco_output_handshake (
    .aclk(aclk), .aresetn(aresetn),
    .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
    .s_axil_wdata(wdata), .s_axil_wstrb(4'hF), .s_axil_wvalid(wvalid),
    .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid),
    .s_axil_bready(bready), .s_axil_araddr(araddr), .s_axil_arvalid(arvalid),
    .s_axil_arready(arready), .s_axil_rdata(rdata), .s_axil_rresp(rresp),
    .s_axil_rvalid(rvalid), .s_axil_rready(rready),
    .fifo_out_ready(rd != wr), .fifo_out_data(mem[rd]), .fifo_pop(fifo_pop),
    .fifo_push(fifo_push), .fifo_push_data(push_data), .fifo_clear_n(clr_n),
    .peripheral_ack_in(ack), .peripheral_request_out(req),
    .shift_out_pulse_n(pso_n), .cable_way_out(way), .cable_data_out(dout),
    .cable_data_oe(oe), .cable_data_in(din), .control_out(ctl),
    .status_in({way, ctl[1:0]}), .attention_in(ctl[2]), .test_pin_n(test_n)
  );

  fco_periph_model i_fco_periph_model (
    .aclk(aclk), .req(req), .data(dout), .pol(m_pol), .delay(m_delay),
    .ack(m_ack), .word(m_word), .count(m_count)
  );

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // --------------------------------------------------------------
  // Checking and closing
  // --------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task results();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  // --------------------------------------------------------------
  // FIFO model and cable timing monitor
  // --------------------------------------------------------------
  // Pop on the sampled pulse; the word stays at the output until then
  always @(posedge aclk) begin
    if (!aresetn) rd <= 3'd0;
    else if (fifo_pop) rd <= rd + 3'd1;
  end

  // Pulse width and data set-up watched on every word, request low time once the request has fallen
  always @(posedge aclk) begin
    prev_req <= req;
    prev_dout <= dout;
    stable <= (dout != prev_dout) ? 0 : stable + 1;
    rlow <= req ? 0 : rlow + 1;
    if (!req && prev_req) fell <= 1'b1;
    if (!pso_n) begin
      plow <= plow + 1;
    end else if (plow != 0) begin
      check(32'(plow), 32'(PULSE_CYC_I));
      plow <= 0;
    end
    if (req && !prev_req) begin
      check(32'(stable * CLK_PERIOD_NS > SETUP_NS), 32'h1);
      if (fell) check(32'(rlow >= REQ_LOW_CYC_I), 32'h1);
    end
  end

  // --------------------------------------------------------------
  // Register bus master
  // --------------------------------------------------------------
  task axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        break;
      end
    end
    bready <= 1'b0;
  endtask : axi_wr

  task axi_rd(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        v = rdata;
        r = rresp;
        break;
      end
    end
    rready <= 1'b0;
  endtask : axi_rd

  task push(input logic [WORD_W-1:0] w);
    @(posedge aclk);
    mem[wr] <= w;
    wr <= wr + 3'd1;
  endtask : push

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task t_idle();
    axi_rd(CTRL_OFS);
    check(v, CTRL_RST);
    axi_rd(STAT_OFS);
    check(32'({v[STAT_ACKFF_BIT], v[STAT_REQ_BIT]}), 32'h2);
    check(32'(v[STAT_TEST_BIT]), 32'h0);
    check(32'({pso_n, req, clr_n, fifo_pop}), 32'hA);
    axi_wr(STAT_OFS, 32'h0000_00FF);
    check(32'(r), 32'(RESP_SLVERR));
    axi_rd(4'h8);
    check(32'(r), 32'(RESP_SLVERR));
    check(v, 32'h0000_0000);
  endtask : t_idle

  task t_pins();
    axi_wr(CTRL_OFS, 32'h0000_005B);
    check(32'(clr_n), 32'h0);
    axi_wr(CTRL_OFS, 32'h0000_0053);
    check(32'({ctl, way, oe, clr_n}), 32'h2F);
    repeat (4) @(posedge aclk);
    axi_rd(STAT_OFS);
    check(32'(v[4:0]), 32'h15);
  endtask : t_pins

  // Three words queued at once: each pop waits for the previous ack
  task t_rise();
    push(18'h3FFFF);
    push(18'h00001);
    push(18'h2A5A5);
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 300 && m_count == k; i++) @(posedge aclk);
      check(32'(m_word), 32'(mem[k]));
    end
    repeat (60) @(posedge aclk);
    check(32'({req, rd}), 32'h3);
    axi_rd(STAT_OFS);
    check(32'(v[STAT_ACKFF_BIT]), 32'h1);
  endtask : t_rise

  // Falling edge mode with a slow peripheral
  task t_fall();
    m_pol <= 1'b1;
    m_delay <= 8'd40;
    repeat (4) @(posedge aclk);
    axi_wr(CTRL_OFS, 32'h0000_0057);
    push(18'h15A3C);
    for (int i = 0; i < 400 && m_count == 3; i++) @(posedge aclk);
    check(32'(m_word), 32'(mem[3]));
    repeat (60) @(posedge aclk);
    check(32'({req, rd}), 32'h4);
  endtask : t_fall

  // Hood fitted, input mode; a polarity flip loops the output latch back
  task t_loop();
    test_n <= 1'b0;
    repeat (4) @(posedge aclk);
    axi_wr(CTRL_OFS, 32'h0000_0001);
    repeat (4) @(posedge aclk);
    axi_rd(STAT_OFS);
    check(32'(v[STAT_TEST_BIT]), 32'h1);
    check(32'(oe), 32'h1);
    axi_wr(CTRL_OFS, 32'h0000_0005);
    for (int i = 0; i < 20 && fifo_push !== 1'b1; i++) @(posedge aclk);
    check(32'({fifo_push, push_data}), {13'h0, 1'b1, mem[3]});
    test_n <= 1'b1;
    repeat (4) @(posedge aclk);
    check(32'(oe), 32'h0);
  endtask : t_loop

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    {rd, wr, prev_req, fell, m_pol, test_n} = 10'h1;
    prev_dout = '0;
    m_delay = 8'd1;
    {mismatches, comparisons, plow, rlow, stable} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_idle();
    t_pins();
    t_rise();
    t_fall();
    t_loop();
    results();
  end

  // Whole run needs a few hundred cycles
  initial begin
    #100000;
    mismatches++;
    results();
  end
endmodule : tb_fco_output_handshake
